// ---- design/sgf_spindle_cfg.sv ----
// Spindle gain, notch filter and emergency stop configuration block.
// Assumes an Avalon-MM master on the system clock and pin inputs from outside.
//
// Contract
// - Interpolation gain set follows function word three
// - Controller changeover request forces gain set two
// - Filter one depth decodes bits 3 to 1
// - Filters two, four, five share depth coding
// - Fixed notch three runs 1125 Hz when set
// - Notch frequency acts only at 50 or more
// - Interpolation tracking control follows bit C
// - Interpolation excitation rate follows bit A
// - Sync mode code 001 selects sync position gain
// - Sync mode tracking and excitation from word four
// - Sync mode gain set from word four
// - Coil changeover allowed during stop deceleration
// - Ready-off after gate delay, zero means 7000 ms
// - Delay expiry before stop applies dynamic brake
// - Decel longer than gate limit makes motor coast
// - Decel time from max speed, zero means 7000
// - High response enabled by word six bit D
// - High response ignored in orientation and interpolation
// - Lead scale applies only with high response
// - Slowdown zero means 85, alarm 23 on drop
// - Slowdown setting -1 disables the check
`timescale 1ns/1ps
module sgf_spindle_cfg #(
  parameter int TICK_CYCLES = sgf_pkg::TICK_CYCLES
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic [5:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic [2:0] I_CTRL_MODE,
  input wire logic [15:0] I_CTRL_INPUT5,
  input wire logic I_ORIENTING,
  input wire logic I_ESTOP,
  input wire logic I_AT_STOP,
  input wire logic [15:0] I_SPEED_PCT,
  output logic O_GAIN_SET2,
  output logic O_EXC_RATE2,
  output logic O_HIGH_GAIN_TRACKING,
  output logic O_SYNC_MODE,
  output logic [15:0] O_POS_GAIN,
  output logic [4:0] O_NOTCH_ACTIVE,
  output logic [14:0] O_NOTCH_DEPTH,
  output logic [15:0] O_FIXED_NOTCH_HZ,
  output logic O_HIGH_RESP,
  output logic [15:0] O_LEAD_SCALE,
  output logic O_READY,
  output logic O_DECEL,
  output logic O_DYN_BRAKE,
  output logic O_COAST,
  output logic O_COIL_CHANGE_OK,
  output logic [7:0] O_ALARM
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  initial begin
    if (TICK_CYCLES < 1) begin
      $error("TICK_CYCLES must be at least one");
    end
  end

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic notch_on(input logic [15:0] hz);
    notch_on = hz >= sgf_pkg::NOTCH_MIN_HZ && hz <= sgf_pkg::NOTCH_MAX_HZ;
  endfunction

  function automatic logic [15:0] ms_or_default(input logic [15:0] ms);
    logic [15:0] v;
    v = (ms == 16'h0000) ? sgf_pkg::ESTOP_DFLT_MS : ms;
    ms_or_default = (v > sgf_pkg::ESTOP_MAX_MS) ? sgf_pkg::ESTOP_MAX_MS : v;
  endfunction

  function automatic logic [2:0] depth_of(input logic [15:0] w, input int pos,
    input logic on);
    depth_of = on ? w[pos +: 3] : 3'h0;
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0] estop_sync;
    logic [1:0] phase;
    logic [31:0] rdata;
    sgf_pkg::sgf_estop_e es;
    logic [TW-1:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic [7:0] alarm;
  } sgf_top_s;

  sgf_top_s st_reg;
  sgf_top_s st_next;

  sgf_cfg_if cfg ();
  logic [sgf_pkg::NUM_CFG*16-1:0] words;

  sgf_cfg_store #(.DEPTH(sgf_pkg::NUM_CFG)) u_store (
    .i_clk(I_CLK_SYS),
    .i_reset(I_RESET),
    .bus(cfg),
    .o_words(words)
  );

  function automatic logic [15:0] word(input logic [5:0] idx);
    word = words[idx*16 +: 16];
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  logic [15:0] fw2, fw3, fw4, fw5, fw6, gate_ms, decel_ms, gain_sync;
  logic [7:0] slow_raw, slow_pct;
  logic interp, sync, estop_seen, estop_clear, estop_rise, slow_check, speed_low;
  logic [4:0] active;

  always_comb begin
    fw2 = word(sgf_pkg::IDX_FUNC_TWO);
    fw3 = word(sgf_pkg::IDX_FUNC_THREE);
    fw4 = word(sgf_pkg::IDX_FUNC_FOUR);
    fw5 = word(sgf_pkg::IDX_FUNC_FIVE);
    fw6 = word(sgf_pkg::IDX_FUNC_SIX);
    gate_ms = ms_or_default(word(sgf_pkg::IDX_GATE_OFF));
    decel_ms = ms_or_default(word(sgf_pkg::IDX_DECEL_TIME));
    gain_sync = word(sgf_pkg::IDX_SYNC_GAIN);
    sync = I_CTRL_MODE == sgf_pkg::MODE_SYNC;
    interp = I_CTRL_MODE == sgf_pkg::MODE_INTERP_A || I_CTRL_MODE == sgf_pkg::MODE_INTERP_B;
    active[0] = notch_on(word(sgf_pkg::IDX_NOTCH_ONE));
    active[1] = notch_on(word(sgf_pkg::IDX_NOTCH_TWO));
    active[2] = fw2[sgf_pkg::B_FIXED_NOTCH];
    active[3] = notch_on(word(sgf_pkg::IDX_NOTCH_FOUR));
    active[4] = notch_on(word(sgf_pkg::IDX_NOTCH_FIVE));
    slow_raw = 8'(word(sgf_pkg::IDX_SLOWDOWN));
    slow_check = slow_raw != sgf_pkg::SLOWDOWN_OFF;
    slow_pct = (slow_raw == 8'h00) ? sgf_pkg::SLOWDOWN_DFLT : slow_raw;
    // Allowed drop is slow_pct of command, so speed must stay at or above the rest
    speed_low = I_SPEED_PCT < 16'(sgf_pkg::PCT_FULL - slow_pct);
    estop_seen = st_reg.estop_sync[2] && st_reg.estop_sync[1];
    // Release also needs both late flops to agree, so a glitch cannot end a stop
    estop_clear = !st_reg.estop_sync[2] && !st_reg.estop_sync[1];
    estop_rise = estop_seen && st_reg.es == sgf_pkg::ES_IDLE;
  end

  // ****************************************
  // Mode outputs
  // ****************************************
  always_comb begin
    O_GAIN_SET2 = I_CTRL_INPUT5[sgf_pkg::B_GAIN2_REQ];
    O_EXC_RATE2 = 1'b0;
    O_HIGH_GAIN_TRACKING = 1'b0;
    if (interp) begin
      O_GAIN_SET2 = O_GAIN_SET2 | fw3[sgf_pkg::B_GAIN_INTERP];
      O_EXC_RATE2 = fw3[sgf_pkg::B_EXC_INTERP];
      O_HIGH_GAIN_TRACKING = fw3[sgf_pkg::B_HGT_INTERP];
    end else if (sync) begin
      O_GAIN_SET2 = O_GAIN_SET2 | fw4[sgf_pkg::B_GAIN_SYNC];
      O_EXC_RATE2 = fw4[sgf_pkg::B_EXC_SYNC];
      O_HIGH_GAIN_TRACKING = fw4[sgf_pkg::B_HGT_SYNC];
    end
    O_SYNC_MODE = sync;
    if (gain_sync < sgf_pkg::SYNC_GAIN_MIN) begin
      O_POS_GAIN = sync ? sgf_pkg::SYNC_GAIN_MIN : 16'h0000;
    end else if (gain_sync > sgf_pkg::SYNC_GAIN_MAX) begin
      O_POS_GAIN = sync ? sgf_pkg::SYNC_GAIN_MAX : 16'h0000;
    end else begin
      O_POS_GAIN = sync ? gain_sync : 16'h0000;
    end
    O_NOTCH_ACTIVE = active;
    O_NOTCH_DEPTH[2:0] = depth_of(fw2, sgf_pkg::B_DEPTH_ONE, active[0]);
    O_NOTCH_DEPTH[5:3] = depth_of(fw2, sgf_pkg::B_DEPTH_TWO, active[1]);
    O_NOTCH_DEPTH[8:6] = 3'h0;
    O_NOTCH_DEPTH[11:9] = depth_of(fw2, sgf_pkg::B_DEPTH_FOUR, active[3]);
    O_NOTCH_DEPTH[14:12] = depth_of(fw2, sgf_pkg::B_DEPTH_FIVE, active[4]);
    O_FIXED_NOTCH_HZ = active[2] ? sgf_pkg::FIXED_NOTCH_HZ : 16'h0000;
    // Orientation and every interpolation mode override the enable
    O_HIGH_RESP = fw6[sgf_pkg::B_HIGH_RESP] && !I_ORIENTING && !interp && !sync;
    if (!O_HIGH_RESP) begin
      O_LEAD_SCALE = 16'h0000;
    end else if (word(sgf_pkg::IDX_LEAD_SCALE) > sgf_pkg::LEAD_SCALE_MAX) begin
      O_LEAD_SCALE = sgf_pkg::LEAD_SCALE_MAX;
    end else begin
      O_LEAD_SCALE = word(sgf_pkg::IDX_LEAD_SCALE);
    end
  end

  // ****************************************
  // Bus slave and emergency stop sequence
  // ****************************************
  logic bus_req;
  logic bus_ack;
  assign bus_req = I_AVS_READ || I_AVS_WRITE;
  assign bus_ack = (I_AVS_WRITE && st_reg.phase == sgf_pkg::BUS_PHASE_MID)
    || (I_AVS_READ && st_reg.phase == sgf_pkg::BUS_PHASE_LAST);

  always_comb begin
    st_next = st_reg;
    st_next.estop_sync = {st_reg.estop_sync[1:0], I_ESTOP};
    // Reads cost one extra wait so that read data stand at the accepting edge
    if (!bus_req || bus_ack) begin
      st_next.phase = sgf_pkg::BUS_PHASE_IDLE;
    end else begin
      st_next.phase = st_reg.phase + 2'h1;
    end
    if (I_AVS_READ && st_reg.phase == sgf_pkg::BUS_PHASE_MID) begin
      if (I_AVS_ADDRESS < 6'(sgf_pkg::NUM_CFG)) begin
        st_next.rdata = {16'h0000, cfg.rd_data};
      end else if (I_AVS_ADDRESS == sgf_pkg::IDX_STATUS) begin
        st_next.rdata = {16'h0000, st_reg.alarm, 4'h0, O_COAST, O_DYN_BRAKE, O_DECEL, O_READY};
      end else if (I_AVS_ADDRESS == sgf_pkg::IDX_DEPTHS) begin
        st_next.rdata = {12'h000, O_NOTCH_ACTIVE, O_NOTCH_DEPTH};
      end else begin
        st_next.rdata = sgf_pkg::UNMAPPED_DATA;
      end
    end
    // Ticks start the cycle after detection, once the sequence has left idle
    if (st_reg.es == sgf_pkg::ES_IDLE) begin
      st_next.tick_cnt = '0;
      st_next.ms_cnt = 16'h0000;
    end else if (st_reg.tick_cnt == TW'(TICK_CYCLES - 1)) begin
      st_next.tick_cnt = '0;
      if (st_reg.ms_cnt != 16'hFFFF) begin
        st_next.ms_cnt = st_reg.ms_cnt + 16'h0001;
      end
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + TW'(1);
    end
    unique case (st_reg.es)
      sgf_pkg::ES_IDLE: begin
        if (estop_rise) begin
          st_next.es = sgf_pkg::ES_DECEL;
        end
      end
      sgf_pkg::ES_DECEL: begin
        if (st_reg.ms_cnt >= gate_ms) begin
          st_next.es = sgf_pkg::ES_OFF;
        end else if (I_AT_STOP) begin
          st_next.es = sgf_pkg::ES_STOPPED;
        end
      end
      sgf_pkg::ES_STOPPED: begin
        if (st_reg.ms_cnt >= gate_ms) begin
          st_next.es = sgf_pkg::ES_OFF;
        end
      end
      sgf_pkg::ES_OFF: begin
        if (estop_clear) begin
          st_next.es = sgf_pkg::ES_IDLE;
        end
      end
    endcase
    // Alarm is sticky until the emergency stop sequence clears it
    if (st_reg.es == sgf_pkg::ES_OFF && estop_clear) begin
      st_next.alarm = 8'h00;
    end
    if (slow_check && speed_low && st_reg.es == sgf_pkg::ES_IDLE) begin
      st_next.alarm = sgf_pkg::ALARM_SLOWDOWN;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg.wr_en = I_AVS_WRITE && bus_ack && I_AVS_BYTEENABLE[1:0] == 2'b11;
  assign cfg.wr_idx = I_AVS_ADDRESS;
  assign cfg.wr_data = I_AVS_WRITEDATA[15:0];
  assign cfg.rd_en = I_AVS_READ && st_reg.phase == sgf_pkg::BUS_PHASE_IDLE;
  assign cfg.rd_idx = I_AVS_ADDRESS;
  assign O_AVS_WAITREQUEST = bus_req && !bus_ack;
  assign O_AVS_READDATA = st_reg.rdata;
  assign O_READY = st_reg.es == sgf_pkg::ES_IDLE || st_reg.es == sgf_pkg::ES_DECEL
    || st_reg.es == sgf_pkg::ES_STOPPED;
  assign O_DECEL = st_reg.es == sgf_pkg::ES_DECEL;
  assign O_DYN_BRAKE = st_reg.es == sgf_pkg::ES_OFF && !I_AT_STOP;
  assign O_COAST = st_reg.es != sgf_pkg::ES_IDLE && decel_ms > gate_ms;
  assign O_COIL_CHANGE_OK = O_DECEL && fw5[sgf_pkg::B_COIL_ALLOW];
  assign O_ALARM = st_reg.alarm;
endmodule

// ---- include/sgf_pkg.sv ----
// Constants, register map and types for the spindle configuration block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package sgf_pkg;
  // ****************************************
  // Register indices (word address = index)
  // ****************************************
  localparam logic [5:0] IDX_DELAY_COMP_TWO = 6'h00;
  localparam logic [5:0] IDX_FUNC_TWO = 6'h01;
  localparam logic [5:0] IDX_FUNC_THREE = 6'h02;
  localparam logic [5:0] IDX_NOTCH_ONE = 6'h03;
  localparam logic [5:0] IDX_NOTCH_TWO = 6'h04;
  localparam logic [5:0] IDX_NOTCH_FOUR = 6'h05;
  localparam logic [5:0] IDX_NOTCH_FIVE = 6'h06;
  localparam logic [5:0] IDX_SYNC_GAIN = 6'h07;
  localparam logic [5:0] IDX_FUNC_FOUR = 6'h08;
  localparam logic [5:0] IDX_FUNC_FIVE = 6'h09;
  localparam logic [5:0] IDX_GATE_OFF = 6'h0A;
  localparam logic [5:0] IDX_DECEL_TIME = 6'h0B;
  localparam logic [5:0] IDX_LEAD_SCALE = 6'h0C;
  localparam logic [5:0] IDX_FUNC_SIX = 6'h0D;
  localparam logic [5:0] IDX_SLOWDOWN = 6'h0E;
  localparam logic [5:0] IDX_STATUS = 6'h0F;
  localparam logic [5:0] IDX_DEPTHS = 6'h10;
  localparam int NUM_CFG = 15;
  localparam logic [31:0] UNMAPPED_DATA = 32'hDEAD_0000;
  // Bus phases: writes land in the middle one, reads wait for the last
  localparam logic [1:0] BUS_PHASE_IDLE = 2'h0;
  localparam logic [1:0] BUS_PHASE_MID = 2'h1;
  localparam logic [1:0] BUS_PHASE_LAST = 2'h2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_DEPTH_ONE = 1;
  localparam int B_FIXED_NOTCH = 4;
  localparam int B_DEPTH_TWO = 5;
  localparam int B_DEPTH_FOUR = 9;
  localparam int B_DEPTH_FIVE = 13;
  localparam int B_GAIN_INTERP = 9;
  localparam int B_EXC_INTERP = 10;
  localparam int B_HGT_INTERP = 12;
  localparam int B_GAIN_SYNC = 1;
  localparam int B_EXC_SYNC = 2;
  localparam int B_HGT_SYNC = 4;
  localparam int B_COIL_ALLOW = 8;
  localparam int B_HIGH_RESP = 13;
  localparam int B_GAIN2_REQ = 12;

  // ****************************************
  // Values and limits
  // ****************************************
  localparam logic [2:0] MODE_SYNC = 3'b001;
  localparam logic [2:0] MODE_INTERP_A = 3'b010;
  localparam logic [2:0] MODE_INTERP_B = 3'b100;
  localparam logic [15:0] NOTCH_MIN_HZ = 16'd50;
  localparam logic [15:0] NOTCH_MAX_HZ = 16'd2250;
  localparam logic [15:0] FIXED_NOTCH_HZ = 16'd1125;
  localparam logic [15:0] ESTOP_MAX_MS = 16'd29900;
  localparam logic [15:0] ESTOP_DFLT_MS = 16'd7000;
  localparam logic [15:0] SYNC_GAIN_MIN = 16'd1;
  localparam logic [15:0] SYNC_GAIN_MAX = 16'd200;
  localparam logic [15:0] LEAD_SCALE_MAX = 16'd10000;
  localparam logic [7:0] SLOWDOWN_DFLT = 8'd85;
  localparam logic [7:0] SLOWDOWN_OFF = 8'hFF;
  localparam logic [7:0] ALARM_SLOWDOWN = 8'd23;
  localparam logic [7:0] PCT_FULL = 8'd100;
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 10;
  localparam int TICK_CYCLES = MS_NS / CLK_NS;

  typedef enum logic [1:0] {
    ES_IDLE = 2'b00,
    ES_DECEL = 2'b01,
    ES_STOPPED = 2'b11,
    ES_OFF = 2'b10
  } sgf_estop_e;
endpackage

// ---- include/sgf_cfg_if.sv ----
// Carrier between the register bus slave and the configuration store.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
interface sgf_cfg_if;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [15:0] wr_data;
  logic rd_en;
  logic [5:0] rd_idx;
  logic [15:0] rd_data;
  logic rd_valid;
  modport ctrl(output wr_en, output wr_idx, output wr_data, output rd_en,
    output rd_idx, input rd_data, input rd_valid);
  modport store(input wr_en, input wr_idx, input wr_data, input rd_en,
    input rd_idx, output rd_data, output rd_valid);
endinterface

// ---- design/sgf_cfg_store.sv ----
// Parameter word store with a registered read port.
// Assumes a synchronous active-high reset and one write per cycle.
`timescale 1ns/1ps
module sgf_cfg_store #(
  parameter int DEPTH = sgf_pkg::NUM_CFG
) (
  input wire logic i_clk,
  input wire logic i_reset,
  sgf_cfg_if.store bus,
  output logic [DEPTH*16-1:0] o_words
);
  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [15:0] rd_data;
    logic rd_valid;
  } sgf_store_s;

  sgf_store_s st_reg;
  sgf_store_s st_next;

  initial begin
    if (DEPTH < 1 || DEPTH > 64) begin
      $error("sgf_cfg_store depth out of range");
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.rd_valid = bus.rd_en;
    if (bus.wr_en && int'(bus.wr_idx) < DEPTH) begin
      st_next.mem[bus.wr_idx] = bus.wr_data;
    end
    if (bus.rd_en) begin
      st_next.rd_data = (int'(bus.rd_idx) < DEPTH) ? st_reg.mem[bus.rd_idx] : 16'h0000;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.rd_data = st_reg.rd_data;
  assign bus.rd_valid = st_reg.rd_valid;
  assign o_words = st_reg.mem;
endmodule

// ---- testbench/sgf_spindle_cfg_sva.sv ----
// Concurrent checks on the spindle configuration block ports.
// Assumes binding to sgf_spindle_cfg on one clock with a sync high reset.
`timescale 1ns/1ps
module sgf_spindle_cfg_sva (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic [2:0] I_CTRL_MODE,
  input wire logic [15:0] I_CTRL_INPUT5,
  input wire logic I_ORIENTING,
  input wire logic I_ESTOP,
  input wire logic O_GAIN_SET2,
  input wire logic O_SYNC_MODE,
  input wire logic [15:0] O_POS_GAIN,
  input wire logic [4:0] O_NOTCH_ACTIVE,
  input wire logic [14:0] O_NOTCH_DEPTH,
  input wire logic [15:0] O_FIXED_NOTCH_HZ,
  input wire logic O_HIGH_RESP,
  input wire logic [15:0] O_LEAD_SCALE,
  input wire logic O_READY,
  input wire logic O_DECEL,
  input wire logic O_DYN_BRAKE,
  input wire logic [7:0] O_ALARM
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  property p_gain_req; I_CTRL_INPUT5[12] |-> O_GAIN_SET2; endproperty
  a_gain_req: assert property (p_gain_req) else $error("gain set two not forced");
  property p_sync; O_SYNC_MODE == (I_CTRL_MODE == sgf_pkg::MODE_SYNC) && (O_SYNC_MODE ?
    O_POS_GAIN inside {[16'h0001:16'h00C8]} : O_POS_GAIN == 16'h0000); endproperty
  a_sync: assert property (p_sync) else $error("sync gain wrong");
  property p_depth; (O_NOTCH_ACTIVE[0] || O_NOTCH_DEPTH[2:0] == 3'h0) && O_NOTCH_DEPTH[8:6]
    == 3'h0 && (O_NOTCH_ACTIVE[4] || O_NOTCH_DEPTH[14:12] == 3'h0); endproperty
  a_depth: assert property (p_depth) else $error("depth on idle filter");
  property p_fixed; O_FIXED_NOTCH_HZ == (O_NOTCH_ACTIVE[2] ? sgf_pkg::FIXED_NOTCH_HZ : 16'h0000);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed notch wrong");
  property p_resp_off; (I_ORIENTING || I_CTRL_MODE inside {3'h1, 3'h2, 3'h4}) |-> !O_HIGH_RESP;
  endproperty
  a_resp_off: assert property (p_resp_off) else $error("high response not ignored");
  property p_lead; O_LEAD_SCALE <= 16'h2710 && (O_HIGH_RESP || O_LEAD_SCALE == 16'h0000);
  endproperty
  a_lead: assert property (p_lead) else $error("lead scale wrong");
  property p_wait_wr; I_AVS_WRITE && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST; endproperty
  a_wait_wr: assert property (p_wait_wr) else $error("write wait too long");
  property p_wait_rd; I_AVS_READ && O_AVS_WAITREQUEST |-> ##[1:2] !O_AVS_WAITREQUEST;
  endproperty
  a_wait_rd: assert property (p_wait_rd) else $error("read wait too long");
  property p_stop_start; $rose(I_ESTOP) && O_READY && !O_DECEL |-> ##[1:5] (O_DECEL || !O_READY);
  endproperty
  a_stop_start: assert property (p_stop_start) else $error("stop not detected");
  property p_brake; O_DYN_BRAKE |-> !O_READY; endproperty
  a_brake: assert property (p_brake) else $error("brake while ready");
  property p_alarm; O_ALARM == 8'h00 || O_ALARM == sgf_pkg::ALARM_SLOWDOWN; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm code wrong");
  c_brake: cover property (O_DYN_BRAKE);
  c_sync: cover property (O_SYNC_MODE && O_GAIN_SET2);
  c_alarm: cover property (O_ALARM == sgf_pkg::ALARM_SLOWDOWN);
endmodule
bind sgf_spindle_cfg sgf_spindle_cfg_sva u_sva (.*);

// ---- testbench/sgf_nc_model.sv ----
// Controller model driving control mode, control input 5 and stop pins.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module sgf_nc_model (
  output logic [2:0] o_mode = 3'h0,
  output logic [15:0] o_ctrl5 = 16'h0000,
  output logic o_orienting = 1'b0,
  output logic o_estop = 1'b0,
  output logic o_at_stop = 1'b0,
  output logic [15:0] o_speed_pct = 16'h0064
);
  // ****
  // Commands
  // ****
  task automatic cmd(input logic [2:0] m, input logic [15:0] c5, input logic ori,
      input logic [15:0] spd);
    o_mode <= m;
    o_ctrl5 <= c5;
    o_orienting <= ori;
    o_speed_pct <= spd;
  endtask
  // Stop pin and standstill flag move together so the bench sets both
  task automatic stop(input logic e, input logic s);
    o_estop <= e;
    o_at_stop <= s;
  endtask
endmodule

// ---- testbench/tb_sgf_spindle_cfg.sv ----
// Self-checking bench for the spindle configuration block.
// Assumes the controller model drives the pins and Avalon-MM reaches the words.
`timescale 1ns/1ps
module tb_sgf_spindle_cfg;
  localparam int TICK = 10;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [3:0] be = 4'hF;
  logic wait_req, orient, estop, at_stop, gs2, exc2, hgt, syncm, hresp, rdy, dec, brk, cst, coil;
  logic [2:0] mode;
  logic [15:0] ctl5, spd, pgain, fhz, lead;
  logic [4:0] nact;
  logic [14:0] ndep;
  logic [7:0] alarm;
  int err_count = 0, num_checks = 0;
  int regs[16] = '{default: 0};
  int modes[4] = '{0, 1, 2, 4};
  int fq[5] = '{0, 49, 50, 2250, 1125};
  always #5 clk = ~clk;
  sgf_nc_model nc (.o_mode(mode), .o_ctrl5(ctl5), .o_orienting(orient), .o_estop(estop),
    .o_at_stop(at_stop), .o_speed_pct(spd));
  sgf_spindle_cfg #(.TICK_CYCLES(TICK)) dut (.I_CLK_SYS(clk), .I_RESET(rst),
    .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
    .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_req),
    .I_CTRL_MODE(mode), .I_CTRL_INPUT5(ctl5), .I_ORIENTING(orient), .I_ESTOP(estop),
    .I_AT_STOP(at_stop), .I_SPEED_PCT(spd), .O_GAIN_SET2(gs2), .O_EXC_RATE2(exc2),
    .O_HIGH_GAIN_TRACKING(hgt), .O_SYNC_MODE(syncm), .O_POS_GAIN(pgain),
    .O_NOTCH_ACTIVE(nact), .O_NOTCH_DEPTH(ndep), .O_FIXED_NOTCH_HZ(fhz),
    .O_HIGH_RESP(hresp), .O_LEAD_SCALE(lead), .O_READY(rdy), .O_DECEL(dec),
    .O_DYN_BRAKE(brk), .O_COAST(cst), .O_COIL_CHANGE_OK(coil), .O_ALARM(alarm));
  // ****
  // Tasks
  // ****
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request holds to the edge that sees waitrequest low; read data are taken there
  task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d,
      input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h0;
    adr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [5:0] a, input int d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
    if (a < 6'h0F) regs[a] = d & ((a == 6'h0E) ? 32'h000000FF : 32'h0000FFFF);
  endtask
  task automatic rreg(input logic [5:0] a);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk("readback", (a < 6'h0F) ? regs[a] : 32'hDEAD0000, q);
  endtask
  task automatic check_ctrl(input int m, input int c5, input bit ori);
    bit it, sy, hr;
    it = (m == 2 || m == 4);
    sy = (m == 1);
    hr = regs[13][13] && !it && !sy && !ori;
    @(negedge clk);
    chk("gain2", c5[12] | it & regs[2][9] | sy & regs[8][1], gs2);
    chk("exc2", it & regs[2][10] | sy & regs[8][2], exc2);
    chk("tracking", it & regs[2][12] | sy & regs[8][4], hgt);
    chk("sync", sy, syncm);
    chk("pos_gain", sy ? (regs[7] > 200 ? 200 : regs[7] < 1 ? 1 : regs[7]) : 0, pgain);
    chk("high_resp", hr, hresp);
    chk("lead", hr ? (regs[12] > 10000 ? 10000 : regs[12]) : 0, lead);
    @(posedge clk);
  endtask
  task automatic check_notch();
    int act, dp, s;
    act = regs[1][4] << 2;
    dp = 0;
    for (int i = 0; i < 4; i++) begin
      s = (i < 2) ? i : i + 1;
      if (regs[3 + i] >= 50) begin
        act |= 1 << s;
        dp |= ((regs[1] >> (1 + 4 * i)) & 7) << (3 * s);
      end
    end
    @(negedge clk);
    chk("notch_active", act, nact);
    chk("notch_depth", dp, ndep);
    chk("fixed_hz", regs[1][4] ? 1125 : 0, fhz);
    @(posedge clk);
  endtask
  task automatic estop_run(input int gate, input int decel, input int stop_at);
    int g, n;
    g = (gate == 0) ? 7000 : gate;
    wreg(6'h0A, gate);
    wreg(6'h0B, decel);
    nc.stop(1'b1, 1'b0);
    n = 0;
    while (dec !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk("decel_start", 1, n >= 2 && n <= 6);
    chk("coast", ((decel == 0) ? 7000 : decel) > g, cst);
    chk("coil_ok", regs[9][8], coil);
    n = 0;
    while (rdy !== 1'b0 && n < 80000) begin
      @(negedge clk);
      n++;
      if (n == stop_at) begin
        @(posedge clk);
        nc.stop(1'b1, 1'b1);
      end
    end
    chk("ready_off", 1, n >= g * TICK - 2 && n <= g * TICK + 2);
    chk("brake", stop_at == 0, brk);
    @(posedge clk);
    nc.stop(1'b0, 1'b0);
    repeat (8) @(negedge clk);
    chk("ready_back", 1, rdy);
    @(posedge clk);
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial begin
    int m, c5;
    bit ori;
    logic [31:0] q;
    void'($urandom(8165));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 15; a++) rreg(6'(a));
    rreg(6'h20);
    bus(1'b0, 6'h0F, 32'h0, 4'hF, q);
    chk("status", 32'h00000001, q);
    for (int a = 0; a < 15; a++) wreg(6'(a), (a == 14) ? $urandom % 101 : $urandom);
    bus(1'b1, 6'h02, 32'h0000FFFF, 4'h1, q);
    bus(1'b1, 6'h20, 32'h0000FFFF, 4'hF, q);
    for (int a = 0; a < 15; a++) rreg(6'(a));
    rreg(6'h20);
    for (int i = 0; i < 16; i++) begin
      m = modes[i % 4];
      wreg(6'h02, $urandom);
      wreg(6'h08, $urandom);
      wreg(6'h0D, $urandom);
      wreg(6'h07, $urandom % 256);
      wreg(6'h0C, $urandom % 12000);
      c5 = $urandom;
      ori = ($urandom % 3) == 0;
      nc.cmd(3'(m), 16'(c5), ori, 16'h0064);
      check_ctrl(m, c5, ori);
    end
    for (int i = 0; i < 8; i++) begin
      wreg(6'h01, $urandom);
      for (int k = 0; k < 4; k++) wreg(6'(k + 3), fq[$urandom % 5]);
      check_notch();
    end
    nc.cmd(3'h0, 16'h0000, 1'b0, 16'h0064);
    wreg(6'h09, 32'h00000100);
    estop_run(3, 2, 5);
    wreg(6'h09, 32'h00000000);
    estop_run(3, 5, 0);
    estop_run(0, 0, 0);
    wreg(6'h0E, 32'h000000FF);
    nc.cmd(3'h0, 16'h0000, 1'b0, 16'h0005);
    repeat (6) @(negedge clk);
    chk("alarm_off", 0, alarm);
    @(posedge clk);
    nc.cmd(3'h0, 16'h0000, 1'b0, 16'h000F);
    wreg(6'h0E, 32'h00000000);
    repeat (6) @(negedge clk);
    chk("alarm_edge", 0, alarm);
    @(posedge clk);
    nc.cmd(3'h0, 16'h0000, 1'b0, 16'h000E);
    repeat (6) @(negedge clk);
    chk("alarm_on", sgf_pkg::ALARM_SLOWDOWN, alarm);
    conclude();
  end
endmodule
